// [rtl/xsk_core.sv]
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// execute slice: commands arrive over APB, one per CMD write.
module xsk_core (
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic             O_SKIP,
    output logic             O_BUSY
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_READ, ST_EXEC, ST_DUMMY, ST_BUSRD
    } xsk_state_t;

    xsk_state_t      st_q;
    xsk_pkg::xsk_cmd_t cmd_q;
    logic [7:0]      acc_q;
    logic [3:0]      flags_q;
    logic [7:0]      tab_ptr_q;
    logic [7:0]      tab_high_q;
    logic [10:0]     pc_q;
    logic [7:0]      mem_rd;
    logic [15:0]     prog_rd;
    logic            mem_we;
    logic [7:0]      mem_wa;
    logic [7:0]      mem_wd;
    logic [7:0]      mem_ra;
    logic            pm_we;
    logic [10:0]     pm_addr;
    logic            skip_q;

    wire logic acc_ph = I_PSEL && I_PENABLE;
    wire logic wr_ev = acc_ph && I_PWRITE && !O_PREADY;
    wire logic rd_ev = acc_ph && !I_PWRITE && !O_PREADY;
    wire logic mem_hit = I_PADDR[11:10] == 2'b01;
    wire logic pm_hit = I_PADDR[11];

    // subtract a - b - borrow; carry is not-borrow, so negative clears it
    function automatic xsk_pkg::xsk_sub_t sub8(input logic [7:0] a,
                                               input logic [7:0] b,
                                               input logic bin);
        xsk_pkg::xsk_sub_t r;
        logic [8:0] full;
        logic [4:0] lo;
        full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
        r.res = full[7:0];
        r.c = !full[8];
        r.nc = !lo[4];
        r.sw = (a[7] != b[7]) && (full[7] != a[7]);
        return r;
    endfunction

    function automatic logic [7:0] swap8(input logic [7:0] v);
        return {v[3:0], v[7:4]};
    endfunction

    xsk_dmem #(.AW(8), .DW(8)) u_dmem (
        .i_clk   (I_CLK),
        .i_we    (mem_we),
        .i_waddr (mem_wa),
        .i_wdata (mem_wd),
        .i_raddr (mem_ra),
        .o_rdata (mem_rd)
    );

    xsk_pmem #(.AW(11), .DW(16)) u_pmem (
        .i_clk   (I_CLK),
        .i_we    (pm_we),
        .i_addr  (pm_addr),
        .i_wdata (I_PWDATA[15:0]),
        .o_rdata (prog_rd)
    );

    // table reads address program memory, bus loads it otherwise
    always_comb begin
        pm_we = wr_ev && pm_hit && st_q == ST_IDLE;
        // bus window reaches the lower 512 program words only
        pm_addr = {2'b00, I_PADDR[10:2]};
        if (st_q != ST_IDLE) begin
            if (cmd_q.op == xsk_pkg::XSK_OP_TAB_LAST) begin
                pm_addr = {3'b111, tab_ptr_q};
            end else begin
                pm_addr = {pc_q[10:8], tab_ptr_q};
            end
        end
    end

    // execution results
    xsk_pkg::xsk_sub_t sr;
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    logic       bit_v;
    logic       ex_we;
    logic [7:0] ex_wd;
    logic       ex_acc_we;
    logic [7:0] ex_acc;
    logic [3:0] ex_flags;
    logic       ex_skip;

    always_comb begin
        dec_v = mem_rd - 8'h01;
        inc_v = mem_rd + 8'h01;
        bit_v = mem_rd[cmd_q.bit_sel];
        sr = sub8(acc_q, mem_rd, 1'b0);
        ex_we = 1'b0;
        ex_wd = mem_rd;
        ex_acc_we = 1'b0;
        ex_acc = acc_q;
        ex_flags = flags_q;
        ex_skip = 1'b0;
        unique case (cmd_q.op)
            xsk_pkg::XSK_OP_BORROW_DIFF_ACC, xsk_pkg::XSK_OP_BORROW_DIFF_MEM:
            begin
                sr = sub8(acc_q, mem_rd, !flags_q[xsk_pkg::XSK_FLAG_C]);
                ex_we = cmd_q.op == xsk_pkg::XSK_OP_BORROW_DIFF_MEM;
                ex_acc_we = !ex_we;
            end
            xsk_pkg::XSK_OP_DIFF_ACC: ex_acc_we = 1'b1;
            xsk_pkg::XSK_OP_DIFF_MEM: ex_we = 1'b1;
            xsk_pkg::XSK_OP_DIFF_IMM: begin
                sr = sub8(acc_q, cmd_q.imm, 1'b0);
                ex_acc_we = 1'b1;
            end
            default: ;
        endcase
        if (ex_we || ex_acc_we) begin
            ex_wd = sr.res;
            ex_acc = sr.res;
            ex_flags[xsk_pkg::XSK_FLAG_C] = sr.c;
            ex_flags[xsk_pkg::XSK_FLAG_NC] = sr.nc;
            ex_flags[xsk_pkg::XSK_FLAG_SW] = sr.sw;
            ex_flags[xsk_pkg::XSK_FLAG_Z] = sr.res == 8'h00;
        end
        unique case (cmd_q.op)
            xsk_pkg::XSK_OP_DEC_SKIP: begin
                ex_we = 1'b1;
                ex_wd = dec_v;
                ex_skip = dec_v == 8'h00;
            end
            xsk_pkg::XSK_OP_DEC_SKIP_ACC: begin
                ex_acc_we = 1'b1;
                ex_acc = dec_v;
                ex_skip = dec_v == 8'h00;
            end
            xsk_pkg::XSK_OP_INC_SKIP: begin
                ex_we = 1'b1;
                ex_wd = inc_v;
                ex_skip = inc_v == 8'h00;
            end
            xsk_pkg::XSK_OP_INC_SKIP_ACC: begin
                ex_acc_we = 1'b1;
                ex_acc = inc_v;
                ex_skip = inc_v == 8'h00;
            end
            xsk_pkg::XSK_OP_SET_BYTE: begin
                ex_we = 1'b1;
                ex_wd = xsk_pkg::XSK_ALL_ONES;
            end
            xsk_pkg::XSK_OP_SET_BIT: begin
                ex_we = 1'b1;
                ex_wd = mem_rd | (8'h01 << cmd_q.bit_sel);
            end
            xsk_pkg::XSK_OP_BIT_SET_SKIP: ex_skip = bit_v;
            xsk_pkg::XSK_OP_BIT_CLR_SKIP: ex_skip = !bit_v;
            xsk_pkg::XSK_OP_SWAP_MEM: begin
                ex_we = 1'b1;
                ex_wd = swap8(mem_rd);
            end
            xsk_pkg::XSK_OP_SWAP_ACC: begin
                ex_acc_we = 1'b1;
                ex_acc = swap8(mem_rd);
            end
            xsk_pkg::XSK_OP_TEST_SKIP: ex_skip = mem_rd == 8'h00;
            xsk_pkg::XSK_OP_LOAD_TEST_SKIP: begin
                ex_acc_we = 1'b1;
                ex_acc = mem_rd;
                ex_skip = mem_rd == 8'h00;
            end
            xsk_pkg::XSK_OP_TAB_CUR, xsk_pkg::XSK_OP_TAB_LAST: begin
                ex_we = 1'b1;
                ex_wd = prog_rd[7:0];
            end
            xsk_pkg::XSK_OP_XOR_ACC, xsk_pkg::XSK_OP_XOR_MEM,
            xsk_pkg::XSK_OP_XOR_IMM: begin
                ex_acc = acc_q ^ (cmd_q.op == xsk_pkg::XSK_OP_XOR_IMM ?
                                  cmd_q.imm : mem_rd);
                ex_wd = ex_acc;
                ex_we = cmd_q.op == xsk_pkg::XSK_OP_XOR_MEM;
                ex_acc_we = !ex_we;
                ex_flags[xsk_pkg::XSK_FLAG_Z] = ex_acc == 8'h00;
            end
            default: ;
        endcase
    end

    // memory port: execute write wins, bus writes only while idle
    always_comb begin
        mem_ra = st_q == ST_IDLE ? I_PADDR[9:2] : cmd_q.addr;
        mem_we = 1'b0;
        mem_wa = cmd_q.addr;
        mem_wd = ex_wd;
        if (st_q == ST_EXEC) begin
            mem_we = ex_we;
        end else if (st_q == ST_IDLE && wr_ev && mem_hit) begin
            mem_we = 1'b1;
            mem_wa = I_PADDR[9:2];
            mem_wd = I_PWDATA[7:0];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st_q <= ST_IDLE;
            skip_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (wr_ev && I_PADDR == xsk_pkg::XSK_REG_CMD) begin
                        st_q <= ST_READ;
                        skip_q <= 1'b0;
                    end else if (rd_ev && mem_hit) begin
                        st_q <= ST_BUSRD;
                    end
                end
                ST_READ: st_q <= ST_EXEC;
                ST_EXEC: begin
                    skip_q <= ex_skip;
                    st_q <= ex_skip ? ST_DUMMY : ST_IDLE;
                end
                ST_DUMMY: st_q <= ST_IDLE;
                ST_BUSRD: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cmd_q <= '0;
        end else if (st_q == ST_IDLE && wr_ev &&
                     I_PADDR == xsk_pkg::XSK_REG_CMD) begin
            cmd_q <= xsk_pkg::xsk_cmd_t'(I_PWDATA[23:0]);
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            acc_q <= xsk_pkg::XSK_ACC_RST;
            flags_q <= xsk_pkg::XSK_FLAG_RST;
            tab_ptr_q <= 8'h00;
            tab_high_q <= 8'h00;
            pc_q <= 11'h000;
        end else if (st_q == ST_EXEC) begin
            if (ex_acc_we) begin
                acc_q <= ex_acc;
            end
            flags_q <= ex_flags;
            if (cmd_q.op == xsk_pkg::XSK_OP_TAB_CUR ||
                cmd_q.op == xsk_pkg::XSK_OP_TAB_LAST) begin
                tab_high_q <= prog_rd[15:8];
            end
            pc_q <= pc_q + (ex_skip ? 11'h002 : 11'h001);
        end else if (st_q == ST_IDLE && wr_ev) begin
            unique case (I_PADDR)
                xsk_pkg::XSK_REG_ACC: acc_q <= I_PWDATA[7:0];
                xsk_pkg::XSK_REG_STATUS: flags_q <= I_PWDATA[3:0];
                xsk_pkg::XSK_REG_TAB_PTR: tab_ptr_q <= I_PWDATA[7:0];
                xsk_pkg::XSK_REG_PC: pc_q <= I_PWDATA[10:0];
                default: ;
            endcase
        end
    end

    // answer: writes one wait state, reads of memory wait for sram
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            if (acc_ph && !O_PREADY && st_q == ST_IDLE && !(rd_ev && mem_hit)) begin
                O_PREADY <= 1'b1;
                O_PSLVERR <= !(mem_hit || pm_hit ||
                               I_PADDR <= xsk_pkg::XSK_REG_STATE);
                unique case (I_PADDR)
                    xsk_pkg::XSK_REG_ACC: O_PRDATA <= {24'h0, acc_q};
                    xsk_pkg::XSK_REG_STATUS: O_PRDATA <= {28'h0, flags_q};
                    xsk_pkg::XSK_REG_TAB_PTR: O_PRDATA <= {24'h0, tab_ptr_q};
                    xsk_pkg::XSK_REG_TAB_HIGH: O_PRDATA <= {24'h0, tab_high_q};
                    xsk_pkg::XSK_REG_PC: O_PRDATA <= {21'h0, pc_q};
                    xsk_pkg::XSK_REG_STATE: O_PRDATA <= {30'h0, skip_q, 1'b0};
                    default: O_PRDATA <= 32'h0000_0000;
                endcase
            end else if (st_q == ST_BUSRD) begin
                O_PREADY <= 1'b1;
                O_PRDATA <= {24'h0, mem_rd};
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_SKIP <= 1'b0;
            O_BUSY <= 1'b0;
        end else begin
            O_SKIP <= st_q == ST_EXEC && ex_skip;
            O_BUSY <= !(st_q == ST_IDLE || st_q == ST_BUSRD) ||
                      (st_q == ST_IDLE && wr_ev &&
                       I_PADDR == xsk_pkg::XSK_REG_CMD);
        end
    end

    dummy_two_a: assert property (
        @(posedge I_CLK) disable iff (!I_RSTN)
        st_q == ST_EXEC && ex_skip |=> st_q == ST_DUMMY ##1 st_q == ST_IDLE)
        else $error("taken skip lacks one dummy cycle");
    no_skip_a: assert property (
        @(posedge I_CLK) disable iff (!I_RSTN)
        st_q == ST_EXEC && !ex_skip |=> st_q == ST_IDLE)
        else $error("untaken skip stalled");
    dec_store_a: assert property (
        @(posedge I_CLK) disable iff (!I_RSTN)
        st_q == ST_EXEC && cmd_q.op == xsk_pkg::XSK_OP_DEC_SKIP |->
        mem_we && mem_wd == mem_rd - 8'h01 && ex_skip == (mem_rd == 8'h01))
        else $error("decrement skip wrong");
    inc_acc_a: assert property (
        @(posedge I_CLK) disable iff (!I_RSTN)
        st_q == ST_EXEC && cmd_q.op == xsk_pkg::XSK_OP_INC_SKIP_ACC |=>
        acc_q == $past(mem_rd) + 8'h01 && flags_q == $past(flags_q))
        else $error("increment to acc wrong");
    carry_sub_a: assert property (
        @(posedge I_CLK) disable iff (!I_RSTN)
        st_q == ST_EXEC && cmd_q.op == xsk_pkg::XSK_OP_DIFF_ACC |=>
        flags_q[0] == ($past(acc_q) >= $past(mem_rd)))
        else $error("subtract carry wrong");
    set_byte_a: assert property (
        @(posedge I_CLK) disable iff (!I_RSTN)
        st_q == ST_EXEC && cmd_q.op == xsk_pkg::XSK_OP_SET_BYTE |->
        mem_we && mem_wd == 8'hFF && ex_flags == flags_q)
        else $error("byte set wrong");
    xor_zero_a: assert property (
        @(posedge I_CLK) disable iff (!I_RSTN)
        st_q == ST_EXEC && cmd_q.op == xsk_pkg::XSK_OP_XOR_ACC |=>
        flags_q[2] == ($past(acc_q) == $past(mem_rd)) &&
        flags_q[1:0] == $past(flags_q[1:0]))
        else $error("xor flags wrong");
    bit_skip_a: assert property (
        @(posedge I_CLK) disable iff (!I_RSTN)
        st_q == ST_EXEC && cmd_q.op == xsk_pkg::XSK_OP_BIT_CLR_SKIP |->
        ex_skip != mem_rd[cmd_q.bit_sel] && !mem_we)
        else $error("bit clear skip wrong");
    // the bench cannot load the last page, so its addressing is watched here
    tab_last_a: assert property (
        @(posedge I_CLK) disable iff (!I_RSTN)
        st_q == ST_READ && cmd_q.op == xsk_pkg::XSK_OP_TAB_LAST |->
        pm_addr[10:8] == 3'b111 && pm_addr[7:0] == tab_ptr_q)
        else $error("last page table read off page");
endmodule
`default_nettype wire

// [rtl/xsk_dmem.sv]
`timescale 1ns/1ps
`default_nettype none
module xsk_dmem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input  wire logic          i_clk,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata
);
    logic [DW-1:0] mem_q [2**AW];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        o_rdata <= mem_q[i_raddr];
    end
endmodule
`default_nettype wire

// [rtl/xsk_pkg.sv]
package xsk_pkg;
    typedef enum logic [4:0] {
        XSK_OP_NOP, XSK_OP_BORROW_DIFF_ACC, XSK_OP_BORROW_DIFF_MEM,
        XSK_OP_DEC_SKIP, XSK_OP_DEC_SKIP_ACC, XSK_OP_INC_SKIP,
        XSK_OP_INC_SKIP_ACC, XSK_OP_SET_BYTE, XSK_OP_SET_BIT,
        XSK_OP_BIT_SET_SKIP, XSK_OP_BIT_CLR_SKIP, XSK_OP_DIFF_ACC,
        XSK_OP_DIFF_MEM, XSK_OP_DIFF_IMM, XSK_OP_SWAP_MEM, XSK_OP_SWAP_ACC,
        XSK_OP_TEST_SKIP, XSK_OP_LOAD_TEST_SKIP, XSK_OP_TAB_CUR,
        XSK_OP_TAB_LAST, XSK_OP_XOR_ACC, XSK_OP_XOR_MEM, XSK_OP_XOR_IMM
    } xsk_op_t;

    localparam int XSK_DATA_W = 8;
    localparam int XSK_MADDR_W = 8;
    localparam int XSK_PADDR_W = 11;
    localparam int XSK_PWORD_W = 16;
    localparam int XSK_BUS_W = 32;

    // flag bit positions in status register
    localparam int XSK_FLAG_C = 0;
    localparam int XSK_FLAG_NC = 1;
    localparam int XSK_FLAG_Z = 2;
    localparam int XSK_FLAG_SW = 3;

    localparam logic [11:0] XSK_REG_ACC = 12'h000;
    localparam logic [11:0] XSK_REG_STATUS = 12'h004;
    localparam logic [11:0] XSK_REG_TAB_PTR = 12'h008;
    localparam logic [11:0] XSK_REG_TAB_HIGH = 12'h00C;
    localparam logic [11:0] XSK_REG_PC = 12'h010;
    localparam logic [11:0] XSK_REG_CMD = 12'h014;
    localparam logic [11:0] XSK_REG_STATE = 12'h018;
    localparam logic [11:0] XSK_REG_MEM = 12'h400;

    localparam logic [7:0] XSK_ACC_RST = 8'h00;
    localparam logic [3:0] XSK_FLAG_RST = 4'h0;
    localparam logic [7:0] XSK_ALL_ONES = 8'hFF;

    typedef struct packed {
        xsk_op_t   op;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] imm;
    } xsk_cmd_t;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       nc;
        logic       sw;
    } xsk_sub_t;
endpackage

// [rtl/xsk_pmem.sv]
`timescale 1ns/1ps
`default_nettype none
module xsk_pmem #(
    parameter int AW = 11,
    parameter int DW = 16
) (
    input  wire logic          i_clk,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    output logic      [DW-1:0] o_rdata
);
    logic [DW-1:0] mem_q [2**AW];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_addr] <= i_wdata;
        end
        o_rdata <= mem_q[i_addr];
    end
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int CMD_CYC = 3;
    logic        I_CLK;
    logic        I_RSTN;
    logic        I_PSEL;
    logic        I_PENABLE;
    logic        I_PWRITE;
    logic [11:0] I_PADDR;
    logic [31:0] I_PWDATA;
    logic [31:0] O_PRDATA;
    logic        O_PREADY;
    logic        O_PSLVERR;
    logic        O_SKIP;
    logic        O_BUSY;
    int          n_mismatch  = 0;
    int          checks_done = 0;
    int          busy_run    = 0;
    int          busy_len    = 0;
    logic        skip_seen   = 1'b0;
    logic [31:0] rd;
    logic        err;

    xsk_core uut (
        .I_CLK     (I_CLK),
        .I_RSTN    (I_RSTN),
        .I_PSEL    (I_PSEL),
        .I_PENABLE (I_PENABLE),
        .I_PWRITE  (I_PWRITE),
        .I_PADDR   (I_PADDR),
        .I_PWDATA  (I_PWDATA),
        .O_PRDATA  (O_PRDATA),
        .O_PREADY  (O_PREADY),
        .O_PSLVERR (O_PSLVERR),
        .O_SKIP    (O_SKIP),
        .O_BUSY    (O_BUSY)
    );

    initial begin
        I_CLK = 1'b0;
        forever #5 I_CLK = ~I_CLK;
    end

    // busy run length shows the extra dummy cycle of a taken skip
    always @(posedge I_CLK) begin
        if (O_SKIP === 1'b1) skip_seen <= 1'b1;
        if (O_BUSY === 1'b1) busy_run <= busy_run + 1;
        else if (busy_run != 0) begin
            busy_len <= busy_run;
            busy_run <= 0;
        end
    end

    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge I_CLK);
        I_PSEL    <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE  <= w;
        I_PADDR   <= a;
        I_PWDATA  <= wd;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_PREADY !== 1'b1 && n < 200);
        rd  = O_PRDATA;
        err = O_PSLVERR;
        I_PSEL    <= 1'b0;
        I_PENABLE <= 1'b0;
        if (O_PREADY !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input string name, input logic [11:0] a,
                        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask

    function automatic logic [11:0] dm(input logic [7:0] a);
        return 12'h400 + {2'b00, a, 2'b00};
    endfunction

    function automatic logic [11:0] pm(input logic [8:0] a);
        return 12'h800 + {1'b0, a, 2'b00};
    endfunction

    // STATE read stalls until the command is over
    task automatic run(input xsk_pkg::xsk_op_t op, input logic [7:0] a,
                       input logic [2:0] b, input logic [7:0] i,
                       input logic sk);
        skip_seen <= 1'b0;
        wr(xsk_pkg::XSK_REG_CMD, {8'h00, op, a, b, i});
        apb(1'b0, xsk_pkg::XSK_REG_STATE, 32'h0);
        check("skip_state", {31'h0, rd[1]}, {31'h0, sk});
        repeat (2) @(posedge I_CLK);
        #1;
        check("skip_pulse", {31'h0, skip_seen}, {31'h0, sk});
        check("cycles", 32'(busy_len), 32'(CMD_CYC + int'(sk)));
    endtask

    task automatic gen(input xsk_pkg::xsk_op_t op, input logic [2:0] b,
                       input logic [7:0] i, input logic [7:0] acc0,
                       input logic [7:0] m, input logic [3:0] st0,
                       input logic to_acc, input logic [7:0] res,
                       input logic [3:0] st, input logic sk);
        wr(xsk_pkg::XSK_REG_ACC, {24'h0, acc0});
        wr(xsk_pkg::XSK_REG_STATUS, {28'h0, st0});
        wr(dm(8'h25), {24'h0, m});
        run(op, 8'h25, b, i, sk);
        rchk("acc", xsk_pkg::XSK_REG_ACC, {24'h0, to_acc ? res : acc0});
        rchk("mem", dm(8'h25), {24'h0, to_acc ? m : res});
        apb(1'b0, xsk_pkg::XSK_REG_STATUS, 32'h0);
        check("flags", {28'h0, rd[3:0]}, {28'h0, st});
    endtask

    // flags must survive: preset all four, expect all four back
    task automatic sk(input xsk_pkg::xsk_op_t op, input logic [2:0] b,
                      input logic [7:0] m, input logic to_acc,
                      input logic [7:0] res, input logic s);
        gen(op, b, 8'h00, 8'h77, m, 4'hF, to_acc, res, 4'hF, s);
    endtask

    task automatic sub(input xsk_pkg::xsk_op_t op, input logic to_acc,
                       input logic use_c, input logic [7:0] a,
                       input logic [7:0] m, input logic ci);
        logic [8:0] r;
        logic [4:0] l;
        logic [3:0] f;
        logic [7:0] mv;
        r  = {1'b0, a} - {1'b0, m} - {8'h00, use_c & ~ci};
        l  = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, use_c & ~ci};
        f  = {(a[7] ^ m[7]) & (a[7] ^ r[7]), r[7:0] == 8'h00, ~l[4], ~r[8]};
        mv = (op == xsk_pkg::XSK_OP_DIFF_IMM) ? ~m : m;
        gen(op, 3'h0, m, a, mv, {3'b000, ci}, to_acc, r[7:0], f, 1'b0);
    endtask

    initial begin
        I_RSTN    = 1'b0;
        I_PSEL    = 1'b0;
        I_PENABLE = 1'b0;
        I_PWRITE  = 1'b0;
        I_PADDR   = 12'h000;
        I_PWDATA  = 32'h0;
        repeat (4) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        rchk("acc_rst", xsk_pkg::XSK_REG_ACC, 32'h0);
        rchk("status_rst", xsk_pkg::XSK_REG_STATUS, 32'h0);
        apb(1'b0, 12'h01C, 32'h0);
        check("unmapped", {31'h0, err}, 32'h1);
        sub(xsk_pkg::XSK_OP_BORROW_DIFF_MEM, 0, 1, 8'h10, 8'h20, 0);
        sub(xsk_pkg::XSK_OP_BORROW_DIFF_MEM, 0, 1, 8'h80, 8'h01, 1);
        sub(xsk_pkg::XSK_OP_BORROW_DIFF_ACC, 1, 1, 8'h00, 8'h00, 0);
        sub(xsk_pkg::XSK_OP_DIFF_ACC, 1, 0, 8'h55, 8'h55, 0);
        sub(xsk_pkg::XSK_OP_DIFF_ACC, 1, 0, 8'h8A, 8'h0B, 1);
        sub(xsk_pkg::XSK_OP_DIFF_MEM, 0, 0, 8'h7F, 8'hFF, 0);
        sub(xsk_pkg::XSK_OP_DIFF_IMM, 1, 0, 8'h00, 8'h01, 1);
        sk(xsk_pkg::XSK_OP_DEC_SKIP, 0, 8'h01, 0, 8'h00, 1);
        sk(xsk_pkg::XSK_OP_DEC_SKIP, 0, 8'h00, 0, 8'hFF, 0);
        sk(xsk_pkg::XSK_OP_DEC_SKIP_ACC, 0, 8'h01, 1, 8'h00, 1);
        sk(xsk_pkg::XSK_OP_DEC_SKIP_ACC, 0, 8'h02, 1, 8'h01, 0);
        sk(xsk_pkg::XSK_OP_INC_SKIP, 0, 8'hFF, 0, 8'h00, 1);
        sk(xsk_pkg::XSK_OP_INC_SKIP, 0, 8'h7F, 0, 8'h80, 0);
        sk(xsk_pkg::XSK_OP_INC_SKIP_ACC, 0, 8'hFF, 1, 8'h00, 1);
        sk(xsk_pkg::XSK_OP_INC_SKIP_ACC, 0, 8'h00, 1, 8'h01, 0);
        sk(xsk_pkg::XSK_OP_SET_BYTE, 0, 8'h12, 0, 8'hFF, 0);
        sk(xsk_pkg::XSK_OP_SET_BIT, 3, 8'h00, 0, 8'h08, 0);
        sk(xsk_pkg::XSK_OP_SET_BIT, 7, 8'h7F, 0, 8'hFF, 0);
        sk(xsk_pkg::XSK_OP_BIT_SET_SKIP, 2, 8'h04, 0, 8'h04, 1);
        sk(xsk_pkg::XSK_OP_BIT_SET_SKIP, 2, 8'hFB, 0, 8'hFB, 0);
        sk(xsk_pkg::XSK_OP_BIT_CLR_SKIP, 0, 8'hFE, 0, 8'hFE, 1);
        sk(xsk_pkg::XSK_OP_BIT_CLR_SKIP, 0, 8'h01, 0, 8'h01, 0);
        sk(xsk_pkg::XSK_OP_SWAP_MEM, 0, 8'hA5, 0, 8'h5A, 0);
        sk(xsk_pkg::XSK_OP_SWAP_ACC, 0, 8'h3C, 1, 8'hC3, 0);
        sk(xsk_pkg::XSK_OP_TEST_SKIP, 0, 8'h00, 0, 8'h00, 1);
        sk(xsk_pkg::XSK_OP_TEST_SKIP, 0, 8'h10, 0, 8'h10, 0);
        sk(xsk_pkg::XSK_OP_LOAD_TEST_SKIP, 0, 8'h00, 1, 8'h00, 1);
        sk(xsk_pkg::XSK_OP_LOAD_TEST_SKIP, 0, 8'h5A, 1, 8'h5A, 0);
        gen(xsk_pkg::XSK_OP_XOR_ACC, 0, 8'h00, 8'h5A, 8'h5A, 4'hB, 1, 8'h00, 4'hF, 0);
        gen(xsk_pkg::XSK_OP_XOR_MEM, 0, 8'h00, 8'h0F, 8'hF0, 4'hF, 0, 8'hFF, 4'hB, 0);
        gen(xsk_pkg::XSK_OP_XOR_IMM, 0, 8'h33, 8'h30, 8'h99, 4'h4, 1, 8'h03, 4'h0, 0);
        wr(pm(9'h145), 32'h0000BEEF);
        wr(xsk_pkg::XSK_REG_PC, 32'h000001F0);
        wr(xsk_pkg::XSK_REG_TAB_PTR, 32'h00000045);
        run(xsk_pkg::XSK_OP_TAB_CUR, 8'h30, 3'h0, 8'h00, 1'b0);
        rchk("tab_low", dm(8'h30), 32'h000000EF);
        rchk("tab_high", xsk_pkg::XSK_REG_TAB_HIGH, 32'h000000BE);
        // last page sits beyond the bus window, only sequencing is seen
        run(xsk_pkg::XSK_OP_TAB_LAST, 8'h31, 3'h0, 8'h00, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
